// *** dss_pkg.sv ***
// Package for the disk seek sequencer: register map, fields, timing counts.
// Assumes a 100 MHz clock and 32-bit APB access to word-aligned registers.
package dss_pkg;

  localparam int          CLK_MHZ          = 100;
  // Settle delay after zero crossing, in microseconds
  localparam int          SETTLE_US        = 1750;
  localparam int          SETTLE_CYC       = SETTLE_US * CLK_MHZ;
  // Seek timeout, in milliseconds
  localparam int          TIMEOUT_MS       = 400;
  localparam int          TIMEOUT_CYC      = TIMEOUT_MS * 1000 * CLK_MHZ;

  localparam int          DCNT_W           = 9;
  localparam logic [8:0]  RTZ_PRESET       = 9'h1ef;  // 495
  localparam logic [8:0]  REV_RELOAD       = 9'h069;  // 105
  localparam logic [8:0]  ONE_LEFT         = 9'h1fe;  // 1 track left
  localparam int          BELOW64_REM      = 64;
  localparam int          BELOW32_REM      = 32;
  localparam int          INTEG_REM        = 16;

  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_DIFF        = 12'h004;
  localparam logic [11:0] ADDR_CYL         = 12'h008;
  localparam logic [11:0] ADDR_STAT        = 12'h00c;

  // Control register fields (write)
  localparam int          CTL_RTZ_BIT      = 1;
  localparam int          CTL_FWD_BIT      = 2;
  localparam int          CTL_REV_BIT      = 3;

  localparam int          ODD_BIT          = 7;
  localparam int          SLOPE_BIT        = 6;

  // Status register fields (read)
  localparam int          ST_ONCYL         = 0;
  localparam int          ST_SKCMP         = 1;
  localparam int          ST_SKERR         = 2;
  localparam int          ST_SEEK          = 3;
  localparam int          ST_RTZ           = 4;
  localparam int          ST_FWD           = 5;

endpackage : dss_pkg

// *** dss_timer.sv ***
// Cycle counter that flags expiry after LIMIT cycles of run.
// Assumes run is synchronous to clk; clearing run restarts the count.
`timescale 1ns/1ns
module dss_timer #(
  parameter int LIMIT = 10
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);

  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;

  assign nxt_cnt = !run ? 32'h0 : (done ? cnt_ff : cnt_ff + 32'h1);
  assign done    = (cnt_ff >= 32'(LIMIT));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 32'h0;
    else        cnt_ff <= nxt_cnt;
  end

endmodule : dss_timer

// *** dss_seq.sv ***
// Disk seek sequencer: difference counter, gate switching, settle and
// timeout, return-to-zero recovery. Registers over APB.
// Assumes transducer pins are asynchronous and pass two flip-flops here.
//
// Operation
// - Bit 7 latched selects odd fine signal
// - Bit 6 latched sets fine slope polarity
// - Zero crossing starts 1.75 ms settle
// - 400 ms timer flags seek error
// - Below 64 remaining reduces velocity gain
// - Below 32 remaining releases converter clamp
// - Integrator enabled over final 16 pulses
// - Cylinder pulse increments difference counter
// - One left: fine gate, high gain
// - RTZ sets flops, presets counter 495
// - RTZ blocks counter until forward limit
// - First even after limit reverses, loads 105
// - Reversing: odd increments, even reloads 105 while limit is set, else increments
// - Recovery phases follow counter decode thresholds
// - Long RTZ raises error at on-cylinder
// - Converter uses five low counter bits
// - Cylinder register cleared on RTZ
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module dss_seq
  import dss_pkg::*;
#(
  parameter int SETTLE_LIM  = SETTLE_CYC,
  parameter int TIMEOUT_LIM = TIMEOUT_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cylPulse,
  input  wire logic        evenTrack,
  input  wire logic        fwdLimit,
  input  wire logic        zeroCross,
  output logic             oddSelect,
  output logic             slopeInvert,
  output logic             below64,
  output logic             clampRelease,
  output logic             integEnable,
  output logic             coarseGate,
  output logic             fineGate,
  output logic             highGainVel,
  output logic      [4:0]  dacCode,
  output logic             reverseDrive,
  output logic             loadHeads,
  output logic             onCylinder,
  output logic             seekComplete,
  output logic             seekError
);

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edge detection
  logic [3:0] syncA_ff;
  logic [3:0] syncB_ff;
  logic       pulsePrev_ff;
  logic       cylEdge;
  logic       evenS;
  logic       limitS;
  logic       zeroS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff     <= 4'h0;
      syncB_ff     <= 4'h0;
      pulsePrev_ff <= 1'b0;
    end else begin
      syncA_ff     <= {cylPulse, evenTrack, fwdLimit, zeroCross};
      syncB_ff     <= syncA_ff;
      pulsePrev_ff <= syncB_ff[3];
    end
  end

  assign cylEdge = syncB_ff[3] & ~pulsePrev_ff;
  assign evenS   = syncB_ff[2];
  assign limitS  = syncB_ff[1];
  assign zeroS   = syncB_ff[0];

  //////////////////////////////////////////////////////////////////////////
  // APB decode; slave answers in the access cycle, no wait states
  logic wrEn;
  logic rdEn;
  logic selCtrl;
  logic selDiff;
  logic selCyl;
  logic selStat;
  logic mapped;

  assign selCtrl = (paddr == ADDR_CTRL);
  assign selDiff = (paddr == ADDR_DIFF);
  assign selCyl  = (paddr == ADDR_CYL);
  assign selStat = (paddr == ADDR_STAT);
  assign mapped  = selCtrl | selDiff | selCyl | selStat;
  assign wrEn    = psel & penable & pwrite & mapped;
  assign rdEn    = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire rtzReq = wrEn & selCtrl & pwdata[CTL_RTZ_BIT];
  wire fwdReq = wrEn & selCtrl & pwdata[CTL_FWD_BIT];
  wire revReq = wrEn & selCtrl & pwdata[CTL_REV_BIT];
  wire anyReq = rtzReq | fwdReq | revReq;

  //////////////////////////////////////////////////////////////////////////
  // Seek state
  typedef enum logic [4:0] {
    DSS_IDLE   = 5'b00001,
    DSS_MOVE   = 5'b00010,
    DSS_RTZFWD = 5'b00100,
    DSS_RTZREV = 5'b01000,
    DSS_SETTLE = 5'b10000
  } dss_state_t;

  dss_state_t state_ff;
  dss_state_t nxt_state;

  logic [8:0] dcnt_ff;
  logic [8:0] nxt_dcnt;
  logic [7:0] cylAddr_ff;
  logic [7:0] nxt_cylAddr;
  logic       odd_ff;
  logic       slope_ff;
  logic       seek_ff;
  logic       fwd_ff;
  logic       rtz_ff;
  logic       firstSeek_ff;
  logic       limitSeen_ff;
  logic       onCyl_ff;
  logic       skCmp_ff;
  logic       skErr_ff;
  logic       timedOut;
  logic       settled;

  // Tracks remaining is the ones-complement of the counter
  wire [8:0] remain   = ~dcnt_ff;
  wire       oneLeft  = (dcnt_ff == ONE_LEFT);
  wire       moving   = (state_ff == DSS_MOVE)
                      | (state_ff == DSS_RTZFWD)
                      | (state_ff == DSS_RTZREV);
  wire       startReq = (state_ff == DSS_IDLE) & anyReq | rtzReq;

  assign below64      = moving & (remain < 9'(BELOW64_REM));
  assign clampRelease = moving & (remain < 9'(BELOW32_REM));
  assign integEnable  = moving & (remain <= 9'(INTEG_REM))
                      & ~oneLeft & ~syncB_ff[3];
  assign fineGate     = (moving & oneLeft)
                      | (state_ff == DSS_SETTLE);
  assign coarseGate   = moving & ~oneLeft;
  assign highGainVel  = fineGate;
  assign dacCode      = dcnt_ff[4:0];
  assign oddSelect    = odd_ff;
  // Forward seeks want negative slope; bit 6 inverts on reverse
  assign slopeInvert  = slope_ff ^ ~fwd_ff;
  assign reverseDrive = ~fwd_ff;
  assign loadHeads    = firstSeek_ff;
  assign onCylinder   = onCyl_ff;
  assign seekComplete = skCmp_ff;
  assign seekError    = skErr_ff;

  //////////////////////////////////////////////////////////////////////////
  // Timers: settle restarts while no zero crossing is seen
  wire settleRun = (state_ff == DSS_SETTLE) & zeroS;

  dss_timer #(.LIMIT(SETTLE_LIM)) u_settle (
    .clk  (clk),
    .rst_n(rst_n),
    .run  (settleRun),
    .done (settled)
  );

  dss_timer #(.LIMIT(TIMEOUT_LIM)) u_timeout (
    .clk  (clk),
    .rst_n(rst_n),
    .run  (seek_ff & ~startReq),
    .done (timedOut)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next-state and counter logic
  wire evenPulse = cylEdge & evenS;
  wire oddPulse  = cylEdge & ~evenS;

  always_comb begin
    nxt_state   = state_ff;
    nxt_dcnt    = dcnt_ff;
    nxt_cylAddr = cylAddr_ff;
    if (wrEn & selCyl)
      nxt_cylAddr = pwdata[7:0];
    case (state_ff)
      DSS_IDLE: begin
        if (wrEn & selDiff)
          nxt_dcnt = pwdata[8:0];
        if (fwdReq | revReq)
          nxt_state = DSS_MOVE;
      end
      DSS_MOVE: begin
        if (cylEdge)
          nxt_dcnt = 9'(dcnt_ff + 9'h001);
        if (zeroS & oneLeft)
          nxt_state = DSS_SETTLE;
      end
      DSS_RTZFWD: begin
        // Counter frozen until limit seen, then first even reverses
        if (limitSeen_ff & evenPulse) begin
          nxt_dcnt  = REV_RELOAD;
          nxt_state = DSS_RTZREV;
        end
      end
      DSS_RTZREV: begin
        if (oddPulse)
          nxt_dcnt = 9'(dcnt_ff + 9'h001);
        else if (evenPulse & limitS)
          nxt_dcnt = REV_RELOAD;
        else if (evenPulse)
          nxt_dcnt = 9'(dcnt_ff + 9'h001);
        if (zeroS & oneLeft)
          nxt_state = DSS_SETTLE;
      end
      DSS_SETTLE: begin
        if (settled)
          nxt_state = DSS_IDLE;
      end
      default: nxt_state = DSS_IDLE;
    endcase
    if (rtzReq) begin
      nxt_dcnt    = RTZ_PRESET;
      nxt_cylAddr = 8'h00;
      nxt_state   = DSS_RTZFWD;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= DSS_IDLE;
      dcnt_ff    <= 9'h1ff;
      cylAddr_ff <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      dcnt_ff    <= nxt_dcnt;
      cylAddr_ff <= nxt_cylAddr;
    end
  end

  // Storage flops capture address bits as the seek starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_ff   <= 1'b0;
      slope_ff <= 1'b0;
    end else if (startReq) begin
      odd_ff   <= nxt_cylAddr[ODD_BIT];
      slope_ff <= nxt_cylAddr[SLOPE_BIT];
    end
  end

  wire settleDone = (state_ff == DSS_SETTLE) & settled;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seek_ff      <= 1'b0;
      fwd_ff       <= 1'b1;
      rtz_ff       <= 1'b0;
      firstSeek_ff <= 1'b0;
      limitSeen_ff <= 1'b0;
    end else begin
      if (startReq)
        seek_ff <= 1'b1;
      else if (settleDone)
        seek_ff <= 1'b0;
      if (startReq) begin
        fwd_ff       <= ~revReq | rtzReq;
        rtz_ff       <= rtzReq;
        firstSeek_ff <= rtzReq;
        limitSeen_ff <= 1'b0;
      end else if (state_ff == DSS_RTZFWD) begin
        if (limitS)
          limitSeen_ff <= 1'b1;
        if (nxt_state == DSS_RTZREV)
          fwd_ff <= 1'b0;
      end else if (settleDone) begin
        rtz_ff       <= 1'b0;
        firstSeek_ff <= 1'b0;
      end
    end
  end

  // Error is sticky until an accepted seek request (any RTZ, or a seek from idle) clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      onCyl_ff <= 1'b1;
      skCmp_ff <= 1'b0;
      skErr_ff <= 1'b0;
    end else begin
      if (startReq) begin
        onCyl_ff <= 1'b0;
        skCmp_ff <= 1'b0;
        skErr_ff <= 1'b0;
      end else if (settleDone) begin
        onCyl_ff <= 1'b1;
        skCmp_ff <= 1'b1;
        if (timedOut)
          skErr_ff <= 1'b1;
      end else if (seek_ff & timedOut & ~rtz_ff) begin
        skErr_ff <= 1'b1;
      end
      if (wrEn & selStat & pwdata[ST_SKCMP] & ~settleDone)
        skCmp_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data, combinational during the access cycle
  logic [31:0] rdMux;
  assign rdMux = selDiff ? {23'h0, dcnt_ff}
               : selCyl  ? {24'h0, cylAddr_ff}
               : selStat ? {26'h0, fwd_ff, rtz_ff, seek_ff,
                            skErr_ff, skCmp_ff, onCyl_ff}
               : 32'h0;

  always_comb begin
    prdata = rdEn ? rdMux : 32'h0;
  end

endmodule : dss_seq

// *** dss_seq_monitor.sv ***
// Checker for the seek sequencer's servo gating and status outputs.
// Assumes it is bound to dss_seq and sees only that module's ports.
`timescale 1ns/1ns
module dss_seq_monitor (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       zeroCross,
  input wire logic       oddSelect,
  input wire logic       below64,
  input wire logic       clampRelease,
  input wire logic       integEnable,
  input wire logic       coarseGate,
  input wire logic       fineGate,
  input wire logic       highGainVel,
  input wire logic [4:0] dacCode,
  input wire logic       onCylinder,
  input wire logic       seekComplete,
  input wire logic       seekError
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_fine_gate: assert property (
    fineGate |-> !coarseGate && highGainVel) else $error("gate overlap");
  a_fine_dac: assert property (
    fineGate |-> dacCode == 5'h1e) else $error("dac not one left");
  a_clamp_order: assert property (
    clampRelease |-> below64) else $error("clamp before below64");
  a_integ_window: assert property (
    integEnable |-> clampRelease) else $error("integrator too early");
  // Depths stay below the smallest settle count used in practice
  a_settle_wait: assert property (
    $rose(onCylinder) |-> $past(zeroCross, 4) && $past(zeroCross, 12))
    else $error("on cylinder without settle");
  a_complete_with: assert property (
    $rose(seekComplete) |-> $rose(onCylinder))
    else $error("complete apart from on cylinder");
  a_error_late: assert property (
    $rose(seekError) && onCylinder |-> $rose(onCylinder))
    else $error("error on settled unit");
  a_odd_hold: assert property (
    !onCylinder && !$past(onCylinder, 2) |-> $stable(oddSelect))
    else $error("odd select moved in seek");
endmodule : dss_seq_monitor

bind dss_seq dss_seq_monitor dss_seq_monitor_i (.clk, .rst_n, .zeroCross,
  .oddSelect, .below64, .clampRelease, .integEnable, .coarseGate,
  .fineGate, .highGainVel, .dacCode, .onCylinder, .seekComplete,
  .seekError);

// *** dss_ctl_model.sv ***
// Disk controller model: tag and bus-line traffic as APB transfers.
// Assumes the bench calls its tasks; it masters the unit's APB port.
`timescale 1ns/1ns
module dss_ctl_model
  import dss_pkg::*;
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        rerr;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  ////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // Counter takes the complement, so length is sent inverted
  task automatic seek(input int len, input logic [7:0] cyl,
                      input logic fwd);
    xfer(1'b1, ADDR_DIFF, 32'(9'h1ff - 9'(len)));
    xfer(1'b1, ADDR_CYL, {24'h0, cyl});
    xfer(1'b1, ADDR_CTRL, 32'h1 << (fwd ? CTL_FWD_BIT : CTL_REV_BIT));
  endtask : seek
  // One unit on this bus stays selected, so no select step is needed
  task automatic rtz();
    xfer(1'b1, ADDR_CTRL, 32'h1 << CTL_RTZ_BIT);
  endtask : rtz
endmodule : dss_ctl_model

// *** tb.sv ***
// Testbench for dss_seq: direct seeks, timeout, return-to-zero recovery.
// Assumes short settle and timeout counts; pins driven on rising edges.
`timescale 1ns/1ns
module tb
  import dss_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cylPulse, evenTrack, fwdLimit, zeroCross, oddSelect, slopeInvert;
  logic below64, clampRelease, integEnable, coarseGate, fineGate;
  logic highGainVel, reverseDrive, loadHeads, onCylinder, seekComplete;
  logic seekError;
  logic [4:0] dacCode;
  int nFail = 0;
  int checkCount = 0;
  int cycles = 0;
  // Short counts keep the run small; RTZ motion outlasts the timeout
  dss_seq #(.SETTLE_LIM(20), .TIMEOUT_LIM(1000)) dss_seq_i (.clk, .rst_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .cylPulse, .evenTrack, .fwdLimit, .zeroCross, .oddSelect, .slopeInvert,
    .below64, .clampRelease, .integEnable, .coarseGate, .fineGate,
    .highGainVel, .dacCode, .reverseDrive, .loadHeads, .onCylinder,
    .seekComplete, .seekError);
  dss_ctl_model dss_ctl_model_i (.clk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    checkCount++;
    if (ok !== 1'b1) begin
      nFail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // Pins pass two sync flops, so hold each level several cycles
  task automatic pulse(input logic even);
    evenTrack <= even;
    cylPulse <= 1'b1;
    repeat (3) @(posedge clk);
    cylPulse <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  task automatic settle(output int n);
    zeroCross <= 1'b1;
    n = 0;
    while (onCylinder !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
  endtask : settle
  task automatic t_regs();
    dss_ctl_model_i.xfer(1'b0, ADDR_STAT, 32'h0);
    chk(dss_ctl_model_i.rdata[ST_ONCYL] === 1'b1, "reset status");
    dss_ctl_model_i.xfer(1'b0, 12'h010, 32'h0);
    chk(dss_ctl_model_i.rerr === 1'b1, "unmapped");
  endtask : t_regs
  task automatic t_direct();
    int n;
    dss_ctl_model_i.seek(70, 8'hc3, 1'b1);
    repeat (2) @(posedge clk);
    chk(oddSelect === 1'b1 && slopeInvert === 1'b1, "odd");
    for (int r = 69; r >= 1; r--) begin
      pulse(1'b0);
      chk(below64 === (r < 64), "below64");
      chk(clampRelease === (r < 32), "clamp");
      chk(fineGate === (r == 1) && coarseGate === (r != 1), "gate");
      chk(highGainVel === (r == 1), "gain");
      chk(integEnable === (r <= 16 && r > 1), "integ");
      if (r < 32) chk(dacCode === 5'(~r), "dac");
    end
    settle(n);
    chk(n >= 20 && n < 30 && seekComplete === 1'b1, "settle");
    chk(seekError === 1'b0, "no error");
    dss_ctl_model_i.xfer(1'b0, ADDR_STAT, 32'h0);
    chk(dss_ctl_model_i.rdata[ST_SEEK] === 1'b0, "seek flop");
    dss_ctl_model_i.xfer(1'b1, ADDR_STAT, 32'h1 << ST_SKCMP);
    @(posedge clk);
    chk(seekComplete === 1'b0 && onCylinder === 1'b1, "cmp clear");
  endtask : t_direct
  task automatic t_timeout();
    int n = 0;
    zeroCross <= 1'b0;
    dss_ctl_model_i.seek(3, 8'h02, 1'b0);
    repeat (2) @(posedge clk);
    chk(slopeInvert === 1'b1 && oddSelect === 1'b0, "rev");
    while (seekError !== 1'b1 && n < 1200) begin
      @(posedge clk);
      n++;
    end
    chk(seekError === 1'b1 && n > 950 && !onCylinder, "timeout");
  endtask : t_timeout
  task automatic t_rtz();
    int n;
    dss_ctl_model_i.rtz();
    repeat (2) @(posedge clk);
    chk(loadHeads === 1'b1 && dacCode === 5'h0f, "preset");
    dss_ctl_model_i.xfer(1'b0, ADDR_CYL, 32'h0);
    chk(dss_ctl_model_i.rdata[7:0] === 8'h00, "cyl clear");
    dss_ctl_model_i.xfer(1'b0, ADDR_STAT, 32'h0);
    chk(dss_ctl_model_i.rdata[5:3] === 3'h7, "rtz flops");
    pulse(1'b0);
    pulse(1'b1);
    chk(dacCode === 5'h0f, "frozen");
    fwdLimit <= 1'b1;
    pulse(1'b0);
    chk(dacCode === 5'h0f, "limit odd");
    pulse(1'b1);
    chk(reverseDrive === 1'b1 && dacCode === 5'h09, "reverse");
    pulse(1'b0);
    chk(dacCode === 5'h0a, "odd step");
    pulse(1'b1);
    chk(dacCode === 5'h09, "reload");
    fwdLimit <= 1'b0;
    pulse(1'b0);
    pulse(1'b1);
    chk(dacCode === 5'h0b, "track 404");
    for (int r = 403; r >= 1; r--) begin
      pulse(!r[0]);
      chk(below64 === (r < 64) && clampRelease === (r < 32), "phase");
    end
    chk(seekError === 1'b0, "no early error");
    settle(n);
    chk(onCylinder === 1'b1 && seekError === 1'b1, "late error");
  endtask : t_rtz
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    cylPulse = 1'b0;
    evenTrack = 1'b0;
    fwdLimit = 1'b0;
    zeroCross = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_direct();
    t_timeout();
    t_rtz();
    give_verdict();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      nFail++;
      give_verdict();
    end
  end
endmodule : tb
